/* File: design/lcs_params.svh */
// Named constants for the low-power DDR command sequencer.
// Assumes inclusion by bare name from every file that needs them.
`ifndef LCS_PARAMS_SVH
`define LCS_PARAMS_SVH

// Burst length and counter width.
`define LCS_BL          3'h4
`define LCS_BL_W        3
// Address width and the all-banks bit.
`define LCS_ADDR_W      13
`define LCS_A10         10
// Stored column bits and bank bits.
`define LCS_COL_W       4
`define LCS_BA_W        2
`define LCS_NBANK       4
// Initial idle time and core clock rate.
`define LCS_INIT_IDLE_US 200
`define LCS_REF_CLK_MHZ 25
// Command codes on {ras_n, cas_n, we_n} while chip select is low.
`define LCS_CMD_LMR     3'h0
`define LCS_CMD_REF     3'h1
`define LCS_CMD_PRE     3'h2
`define LCS_CMD_ACT     3'h3
`define LCS_CMD_WR      3'h4
`define LCS_CMD_RD      3'h5
`define LCS_CMD_BST     3'h6
`define LCS_CMD_NOP     3'h7
// Status vector bit order.
`define LCS_ST_SR       0
`define LCS_ST_PDA      1
`define LCS_ST_PDP      2
`define LCS_ST_VIOL     3
`define LCS_ST_BANK     4
`define LCS_ST_W        8

`endif

/* File: design/lcs_pkg.sv */
// Types shared by the sequencer modules.
// Assumes lcs_params.svh is on the include path.
`default_nettype none
package lcs_pkg;
    typedef enum logic [1:0] {
        LCS_PWR_ACTIVE,
        LCS_PWR_PD_PRE,
        LCS_PWR_PD_ACT,
        LCS_PWR_SELF_REF
    } lcs_pwr_e;
    typedef enum logic [3:0] {
        LCS_C_DESEL, LCS_C_NOP, LCS_C_ACT, LCS_C_RD, LCS_C_WR,
        LCS_C_PRE, LCS_C_REF, LCS_C_LMR, LCS_C_BST
    } lcs_cmd_e;
    typedef logic [31:0] lcs_word_t;
    typedef logic [3:0]  lcs_mask_t;
endpackage : lcs_pkg
`default_nettype wire

/* File: design/lcs_lane_if.sv */
// Bundle between the command core and the byte-lane logic.
// Assumes both ends run on the link clock.
`default_nettype none
interface lcs_lane_if;
    import lcs_pkg::*;
    logic      x32;      // Organisation is 32 bits wide.
    lcs_mask_t dm;       // Write masks from the pins.
    lcs_mask_t dqs_in;   // Strobes from the pins.
    lcs_word_t dq_in;    // Data from the pins.
    logic      wr_beat;  // A strobe edge on an enabled lane.
    lcs_mask_t byte_we;  // Bytes to store for this beat.
    lcs_word_t wr_word;  // Data word for this beat.
    logic      rd_fire;  // Launch one read word at the next edge.
    lcs_word_t rd_word;  // Read word to launch.
    lcs_word_t dq_out;
    lcs_mask_t dq_oe;
    lcs_mask_t dqs_out;
    lcs_mask_t dqs_oe;
    modport core (output x32, dm, dqs_in, dq_in, rd_fire, rd_word,
                  input wr_beat, byte_we, wr_word, dq_out, dq_oe,
                  dqs_out, dqs_oe);
    modport lane (input x32, dm, dqs_in, dq_in, rd_fire, rd_word,
                  output wr_beat, byte_we, wr_word, dq_out, dq_oe,
                  dqs_out, dqs_oe);
endinterface : lcs_lane_if
`default_nettype wire

/* File: design/lcs_data_lane.sv */
// Byte-lane strobes, masks and read output.
// Assumes pins launched on the link clock.
`default_nettype none
module lcs_data_lane
    import lcs_pkg::*;
(
    input wire logic ck,     // Link clock.
    input wire logic rst_ck, // Reset, already timed to the link clock.
    lcs_lane_if.lane lane    // Bundle to the command core.
);
    lcs_mask_t dqs_prev_r;
    lcs_mask_t dqs_edge;
    logic      dqs_tog_r;

    // In the 16-bit organisation only lanes 0 and 1 exist.
    function automatic lcs_mask_t lane_map(input logic x32,
                                           input lcs_mask_t v);
        return x32 ? v : {2'h0, v[1:0]};
    endfunction : lane_map

    // Last strobes, for edge detection.
    always_ff @(posedge ck or posedge rst_ck) begin
        if (rst_ck) begin
            dqs_prev_r <= 4'h0;
        end else begin
            dqs_prev_r <= lane.dqs_in;
        end
    end

    // Each strobe and mask acts on its own byte.
    assign dqs_edge     = lane_map(lane.x32, lane.dqs_in ^ dqs_prev_r);
    assign lane.wr_beat = |dqs_edge;
    assign lane.byte_we = dqs_edge & ~lane_map(lane.x32, lane.dm);
    assign lane.wr_word = lane.dq_in;

    // Read words leave from flops; the strobe toggles once per word.
    always_ff @(posedge ck or posedge rst_ck) begin
        if (rst_ck) begin
            lane.dq_out  <= 32'h0;
            lane.dq_oe   <= 4'h0;
            lane.dqs_out <= 4'h0;
            lane.dqs_oe  <= 4'h0;
            dqs_tog_r    <= 1'b0;
        end else if (lane.rd_fire) begin
            lane.dq_out  <= lane.rd_word;
            lane.dq_oe   <= lane_map(lane.x32, 4'hf);
            lane.dqs_out <= lane_map(lane.x32, {4{~dqs_tog_r}});
            lane.dqs_oe  <= lane_map(lane.x32, 4'hf);
            dqs_tog_r    <= ~dqs_tog_r;
        end else begin
            lane.dq_out  <= 32'h0;
            lane.dq_oe   <= 4'h0;
            lane.dqs_out <= 4'h0;
            lane.dqs_oe  <= 4'h0;
            dqs_tog_r    <= 1'b0;
        end
    end
endmodule : lcs_data_lane
`default_nettype wire

/* File: design/lcs_top.sv */
// Command sequencing and byte lanes of a low-power DDR device.
// Assumes a controller drives ck and pins; ref_clk never stops.
`include "lcs_params.svh"
`default_nettype none
module lcs_top
    import lcs_pkg::*;
#(
    parameter int unsigned INIT_IDLE_CYC =
        `LCS_INIT_IDLE_US * `LCS_REF_CLK_MHZ // Core cycles of quiet start.
) (
    input  wire logic                 ref_clk,   // Core clock, 25 MHz.
    input  wire logic                 rst,       // Async reset, high.
    input  wire logic                 ck,        // Link clock from host.
    input  wire logic                 cke,       // Clock enable pin.
    input  wire logic                 cs_n,      // Chip select, low.
    input  wire logic                 ras_n,     // Row strobe, low.
    input  wire logic                 cas_n,     // Column strobe, low.
    input  wire logic                 we_n,      // Write enable, low.
    input  wire logic [`LCS_BA_W-1:0]  ba,        // Bank address.
    input  wire logic [`LCS_ADDR_W-1:0] addr,     // Row or column address.
    input  wire logic                 x32_mode,  // Strap: 32-bit organisation.
    input  wire logic [1:0]           cas_lat,   // Strap: CAS latency.
    input  wire lcs_pkg::lcs_mask_t   dm,        // Write masks.
    input  wire lcs_pkg::lcs_mask_t   dqs_i,     // Strobe pin inputs.
    input  wire lcs_pkg::lcs_word_t   dq_i,      // Data pin inputs.
    output lcs_pkg::lcs_word_t        dq_o,      // Data pin outputs.
    output lcs_pkg::lcs_mask_t        dq_oe,     // Data enables per byte.
    output lcs_pkg::lcs_mask_t        dqs_o,     // Strobe pin outputs.
    output lcs_pkg::lcs_mask_t        dqs_oe,    // Strobe enables.
    output lcs_pkg::lcs_pwr_e         pwr_state, // Power state, core clock.
    output logic [`LCS_NBANK-1:0]     banks_open, // Open banks, core clock.
    output logic                      init_done, // Idle period elapsed.
    output logic                      init_violation // Early command seen.
);
    lcs_lane_if lane_bus ();

    logic                        rst_ck_q1, rst_ck;
    logic                        x32_q1, x32_r;
    logic [1:0]                  cl_q1, cl_r;
    logic                        idone_q1, idone_ck_r;
    logic                        cke_r;
    lcs_pwr_e                    pwr_r;
    logic [`LCS_NBANK-1:0]       bank_r;
    logic                        ap_pend_r;
    logic [`LCS_BA_W-1:0]        ap_bank_r;
    logic [1:0]                  rd_dly_r;
    logic [`LCS_BL_W-1:0]        rd_left_r, wr_left_r;
    logic [`LCS_BA_W+`LCS_COL_W-1:0] rd_addr_r, wr_addr_r;
    logic                        viol_r;
    lcs_cmd_e                    cmd;
    logic                        exec;
    logic                        rd_last, wr_last;
    lcs_word_t                   mem [0:(1<<(`LCS_BA_W+`LCS_COL_W))-1];
    logic [`LCS_ST_W-1:0]        st_ck, st_q1, st_r;
    logic [31:0]                 init_cnt_r;

    // Turns the command pins into one command name.
    function automatic lcs_cmd_e decode(input logic c_n,
                                        input logic [2:0] rcw);
        lcs_cmd_e c;
        c = LCS_C_NOP;
        if (c_n) begin
            c = LCS_C_DESEL;
        end else begin
            case (rcw)
                `LCS_CMD_LMR: c = LCS_C_LMR;
                `LCS_CMD_REF: c = LCS_C_REF;
                `LCS_CMD_PRE: c = LCS_C_PRE;
                `LCS_CMD_ACT: c = LCS_C_ACT;
                `LCS_CMD_WR:  c = LCS_C_WR;
                `LCS_CMD_RD:  c = LCS_C_RD;
                `LCS_CMD_BST: c = LCS_C_BST;
                default:      c = LCS_C_NOP;
            endcase
        end
        return c;
    endfunction : decode

    // The link-side reset asserts at once but releases on a ck edge.
    always_ff @(posedge ck or posedge rst) begin
        if (rst) begin
            rst_ck_q1 <= 1'b1;
            rst_ck    <= 1'b1;
        end else begin
            rst_ck_q1 <= 1'b0;
            rst_ck    <= rst_ck_q1;
        end
    end

    // Straps and init flag: two flops each.
    always_ff @(posedge ck or posedge rst_ck) begin
        if (rst_ck) begin
            x32_q1     <= 1'b0;
            x32_r      <= 1'b0;
            cl_q1      <= 2'h0;
            cl_r       <= 2'h0;
            idone_q1   <= 1'b0;
            idone_ck_r <= 1'b0;
        end else begin
            x32_q1     <= x32_mode;
            x32_r      <= x32_q1;
            cl_q1      <= cas_lat;
            cl_r       <= cl_q1;
            idone_q1   <= init_done;
            idone_ck_r <= idone_q1;
        end
    end

    // Commands count with CKE high twice.
    assign cmd  = decode(cs_n, {ras_n, cas_n, we_n});
    assign exec = (pwr_r == LCS_PWR_ACTIVE) && cke_r && cke;

    // CKE history marks the edge at which it falls.
    always_ff @(posedge ck or posedge rst_ck) begin
        if (rst_ck) begin
            cke_r <= 1'b0;
        end else begin
            cke_r <= cke;
        end
    end

    // Power state; power-down entry never cuts a burst.
    always_ff @(posedge ck or posedge rst_ck) begin
        if (rst_ck) begin
            pwr_r <= LCS_PWR_ACTIVE;
        end else begin
            case (pwr_r)
                LCS_PWR_ACTIVE: begin
                    if (cke_r && !cke) begin
                        if (cmd == LCS_C_REF) begin
                            pwr_r <= LCS_PWR_SELF_REF;
                        end else if (|bank_r) begin
                            pwr_r <= LCS_PWR_PD_ACT;
                        end else begin
                            pwr_r <= LCS_PWR_PD_PRE;
                        end
                    end
                end
                LCS_PWR_PD_PRE, LCS_PWR_PD_ACT: begin
                    if (cke) begin
                        pwr_r <= LCS_PWR_ACTIVE;
                    end
                end
                LCS_PWR_SELF_REF: begin
                    if (cke) begin
                        pwr_r <= LCS_PWR_ACTIVE;
                    end
                end
                default: pwr_r <= LCS_PWR_ACTIVE;
            endcase
        end
    end

    // A burst ends on its last beat; auto precharge closes it then.
    assign rd_last = (rd_left_r == `LCS_BL_W'(1)) && (rd_dly_r == 2'h0);
    assign wr_last = (wr_left_r == `LCS_BL_W'(1)) && lane_bus.wr_beat;

    // Open banks. A precharge with A10 high ignores the bank address.
    always_ff @(posedge ck or posedge rst_ck) begin
        if (rst_ck) begin
            bank_r    <= '0;
            ap_pend_r <= 1'b0;
            ap_bank_r <= '0;
        end else begin
            if (ap_pend_r && (rd_last || wr_last)) begin
                bank_r[ap_bank_r] <= 1'b0;
                ap_pend_r         <= 1'b0;
            end
            if (exec) begin
                case (cmd)
                    LCS_C_ACT: bank_r[ba] <= 1'b1;
                    LCS_C_PRE: begin
                        if (addr[`LCS_A10]) begin
                            bank_r <= '0;
                        end else begin
                            bank_r[ba] <= 1'b0;
                        end
                    end
                    LCS_C_RD, LCS_C_WR: begin
                        ap_pend_r <= addr[`LCS_A10];
                        ap_bank_r <= ba;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Read: wait CL-1 edges, then one word per cycle.
    always_ff @(posedge ck or posedge rst_ck) begin
        if (rst_ck) begin
            rd_dly_r  <= 2'h0;
            rd_left_r <= '0;
            rd_addr_r <= '0;
        end else if (exec && cmd == LCS_C_RD) begin
            rd_dly_r  <= (cl_r == 2'h0) ? 2'h0 : cl_r - 2'h1;
            rd_left_r <= `LCS_BL;
            rd_addr_r <= {ba, addr[`LCS_COL_W-1:0]};
        end else if (exec && cmd == LCS_C_BST) begin
            rd_left_r <= '0;
        end else if (rd_dly_r != 2'h0) begin
            rd_dly_r <= rd_dly_r - 2'h1;
        end else if (rd_left_r != '0) begin
            rd_left_r <= rd_left_r - `LCS_BL_W'(1);
            rd_addr_r <= rd_addr_r + 1'b1;
        end
    end

    // Write burst: each strobe edge on an enabled lane takes one word.
    always_ff @(posedge ck or posedge rst_ck) begin
        if (rst_ck) begin
            wr_left_r <= '0;
            wr_addr_r <= '0;
        end else if (exec && cmd == LCS_C_WR) begin
            wr_left_r <= `LCS_BL;
            wr_addr_r <= {ba, addr[`LCS_COL_W-1:0]};
        end else if (exec && cmd == LCS_C_BST) begin
            wr_left_r <= '0;
        end else if (lane_bus.wr_beat && wr_left_r != '0) begin
            wr_left_r <= wr_left_r - `LCS_BL_W'(1);
            wr_addr_r <= wr_addr_r + 1'b1;
        end
    end

    // Storage keeps bank and low column only; row bits are not decoded,
    // which trades capacity for a small model of the array.
    always_ff @(posedge ck) begin
        if (lane_bus.wr_beat && wr_left_r != '0) begin
            for (int i = 0; i < 4; i++) begin
                if (lane_bus.byte_we[i]) begin
                    mem[wr_addr_r][i*8 +: 8] <= lane_bus.wr_word[i*8 +: 8];
                end
            end
        end
    end

    // Early commands are remembered.
    always_ff @(posedge ck or posedge rst_ck) begin
        if (rst_ck) begin
            viol_r <= 1'b0;
        end else if (exec && !idone_ck_r && cmd != LCS_C_NOP
                     && cmd != LCS_C_DESEL) begin
            viol_r <= 1'b1;
        end
    end

    // Pins to the lane module.
    assign lane_bus.x32     = x32_r;
    assign lane_bus.dm      = dm;
    assign lane_bus.dqs_in  = dqs_i;
    assign lane_bus.dq_in   = dq_i;
    assign lane_bus.rd_fire = (rd_left_r != '0) && (rd_dly_r == 2'h0);
    assign lane_bus.rd_word = mem[rd_addr_r]
                              & {{16{x32_r}}, 16'hffff};
    assign dq_o   = lane_bus.dq_out;
    assign dq_oe  = lane_bus.dq_oe;
    assign dqs_o  = lane_bus.dqs_out;
    assign dqs_oe = lane_bus.dqs_oe;

    lcs_data_lane u_lane (
        .ck     (ck),
        .rst_ck (rst_ck),
        .lane   (lane_bus)
    );

    // Status levels on the link side.
    always_comb begin
        st_ck = '0;
        st_ck[`LCS_ST_SR]  = (pwr_r == LCS_PWR_SELF_REF);
        st_ck[`LCS_ST_PDA] = (pwr_r == LCS_PWR_PD_ACT);
        st_ck[`LCS_ST_PDP] = (pwr_r == LCS_PWR_PD_PRE);
        st_ck[`LCS_ST_VIOL] = viol_r;
        st_ck[`LCS_ST_BANK +: `LCS_NBANK] = bank_r;
    end

    // Each status bit is an independent level, so two flops suffice.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q1 <= '0;
            st_r  <= '0;
        end else begin
            st_q1 <= st_ck;
            st_r  <= st_q1;
        end
    end

    // Core-side outputs.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwr_state      <= LCS_PWR_ACTIVE;
            banks_open     <= '0;
            init_violation <= 1'b0;
        end else begin
            if (st_r[`LCS_ST_SR]) begin
                pwr_state <= LCS_PWR_SELF_REF;
            end else if (st_r[`LCS_ST_PDA]) begin
                pwr_state <= LCS_PWR_PD_ACT;
            end else if (st_r[`LCS_ST_PDP]) begin
                pwr_state <= LCS_PWR_PD_PRE;
            end else begin
                pwr_state <= LCS_PWR_ACTIVE;
            end
            banks_open     <= st_r[`LCS_ST_BANK +: `LCS_NBANK];
            init_violation <= st_r[`LCS_ST_VIOL];
        end
    end

    // The idle period is timed on ref_clk, since ck may not run yet.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            init_cnt_r <= 32'h0;
            init_done  <= 1'b0;
        end else if (!init_done) begin
            init_cnt_r <= init_cnt_r + 32'h1;
            init_done  <= (init_cnt_r + 32'h1) >= 32'(INIT_IDLE_CYC);
        end
    end
endmodule : lcs_top
`default_nettype wire

/* File: dv/lcs_ctrl_model.sv */
// Controller model: command, address and write pins.
// Assumes a free-running ck; one task at a time.
`default_nettype none
module lcs_ctrl_model
    import lcs_pkg::*;
(
    input  wire logic        ck,    // Link clock.
    output var  logic        cke,   // Clock enable.
    output var  logic [3:0]  cmd_n, // Chip select, row, column, write.
    output var  logic [1:0]  ba,    // Bank address.
    output var  logic [12:0] addr,  // Row or column address.
    output var  lcs_mask_t   dm,    // Write masks.
    output var  lcs_mask_t   dqs_i, // Write strobes.
    output var  lcs_word_t   dq_i   // Write data.
);
    timeunit 1ns;
    timeprecision 1ns;
    // Deselect from time zero.
    initial begin
        {cke, cmd_n, ba, addr, dm, dqs_i, dq_i} = {1'b1, 4'hf, 55'h0};
    end
    // One command, then deselect; cke stays at k.
    task automatic issue(input logic [2:0] code, input logic [1:0] b,
                         input logic [12:0] a, input logic k);
        @(negedge ck);
        {cke, cmd_n, ba, addr} <= {k, 1'b0, code, b, a};
        @(negedge ck);
        cmd_n <= 4'hf;
    endtask : issue
    // Four strobe toggles, one word each.
    task automatic burst(input lcs_word_t w [4], input lcs_mask_t m [4]);
        for (int i = 0; i < 4; i++) begin
            {dq_i, dm, dqs_i} <= {w[i], m[i], ~dqs_i};
            @(negedge ck);
        end
        dq_i <= ~dq_i; // Released data must not look like the last word.
    endtask : burst
endmodule : lcs_ctrl_model
`default_nettype wire

/* File: dv/lcs_top_asserts.sv */
// Assertions on the ports of lcs_top.
// Assumes ck and ref_clk are unrelated.
`include "lcs_params.svh"
`default_nettype none
module lcs_top_asserts
    import lcs_pkg::*;
#(
    parameter int unsigned INIT_IDLE_CYC = 20 // Quiet start, core cycles.
) (
    input wire logic                   ref_clk,    // Core clock.
    input wire logic                   rst,        // Async reset.
    input wire logic                   ck,         // Link clock.
    input wire logic                   cke,        // Clock enable.
    input wire logic                   cs_n,       // Chip select.
    input wire logic                   ras_n,      // Row strobe.
    input wire logic                   cas_n,      // Column strobe.
    input wire logic                   we_n,       // Write enable.
    input wire logic [`LCS_ADDR_W-1:0] addr,       // Address.
    input wire logic                   x32_mode,   // Width strap.
    input wire logic [1:0]             cas_lat,    // Latency strap.
    input wire lcs_pkg::lcs_word_t     dq_o,       // Read data.
    input wire lcs_pkg::lcs_mask_t     dq_oe,      // Data enables.
    input wire lcs_pkg::lcs_mask_t     dqs_o,      // Read strobes.
    input wire lcs_pkg::lcs_mask_t     dqs_oe,     // Strobe enables.
    input wire lcs_pkg::lcs_pwr_e      pwr_state,  // Power state.
    input wire logic [`LCS_NBANK-1:0]  banks_open, // Open banks.
    input wire logic                   init_done   // Idle period over.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        cke_q;    // Clock enable at the previous ck edge.
    int unsigned init_cnt; // Core edges since reset.
    logic        taken;    // A command executes at this ck edge.
    // Command taken: cke high two edges.
    assign taken = cke && cke_q && !cs_n;
    always_ff @(posedge ck or posedge rst) begin
        if (rst)
            cke_q <= 1'b0;
        else
            cke_q <= cke;
    end
    // Saturates, so it never wraps.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            init_cnt <= 0;
        else if (init_cnt < INIT_IDLE_CYC + 4)
            init_cnt <= init_cnt + 1;
    end
    property p_rd_cl2;
        @(posedge ck) disable iff (rst)
        (taken && {ras_n, cas_n, we_n} == `LCS_CMD_RD && cas_lat == 2'h2)
            |-> ##3 (dq_oe != 4'h0 && (dqs_o & dqs_oe) == dqs_oe);
    endproperty
    a_rd_cl2: assert property (p_rd_cl2)
        else $error("read word late");
    property p_oe_pair;
        @(posedge ck) disable iff (rst) dq_oe != 4'h0 |-> dqs_oe == dq_oe;
    endproperty
    a_oe_pair: assert property (p_oe_pair)
        else $error("enable mismatch");
    property p_x32;
        @(posedge ck) disable iff (rst)
        (x32_mode && $past(x32_mode, 3) && dq_oe != 4'h0) |-> dq_oe == 4'hf;
    endproperty
    a_x32: assert property (p_x32)
        else $error("wide read lanes wrong");
    property p_x16;
        @(posedge ck) disable iff (rst)
        (!x32_mode && !$past(x32_mode, 3))
            |-> (dq_oe[3:2] == 2'h0 && dq_o[31:16] == 16'h0);
    endproperty
    a_x16: assert property (p_x16)
        else $error("upper lanes driven");
    property p_pd_act;
        @(posedge ref_clk) disable iff (rst)
        pwr_state == LCS_PWR_PD_ACT |-> banks_open != 4'h0;
    endproperty
    a_pd_act: assert property (p_pd_act)
        else $error("active power-down idle");
    property p_pd_pre;
        @(posedge ref_clk) disable iff (rst)
        pwr_state == LCS_PWR_PD_PRE |-> banks_open == 4'h0;
    endproperty
    a_pd_pre: assert property (p_pd_pre)
        else $error("precharge power-down open");
    property p_sr_hold;
        @(posedge ck) disable iff (rst)
        (pwr_state == LCS_PWR_SELF_REF && !cke && !cke_q)
            |=> pwr_state == LCS_PWR_SELF_REF;
    endproperty
    a_sr_hold: assert property (p_sr_hold)
        else $error("self refresh left early");
    property p_pre_all;
        @(posedge ck) disable iff (rst)
        (taken && {ras_n, cas_n, we_n} == `LCS_CMD_PRE && addr[`LCS_A10])
            |-> ##[1:5] banks_open == 4'h0;
    endproperty
    a_pre_all: assert property (p_pre_all)
        else $error("bank open after precharge all");
    property p_init;
        @(posedge ref_clk) disable iff (rst)
        init_done ? init_cnt >= INIT_IDLE_CYC - 1
                  : init_cnt <= INIT_IDLE_CYC + 2;
    endproperty
    a_init: assert property (p_init)
        else $error("init done at wrong cycle");
endmodule : lcs_top_asserts
bind lcs_top lcs_top_asserts #(.INIT_IDLE_CYC(INIT_IDLE_CYC)) u_chk (
    .ref_clk, .rst, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr,
    .x32_mode, .cas_lat, .dq_o, .dq_oe, .dqs_o, .dqs_oe, .pwr_state,
    .banks_open, .init_done);
`default_nettype wire

/* File: dv/testbench.sv */
// Bench for the command sequencer top.
// Assumes the controller model drives pins on falling ck.
`include "lcs_params.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import lcs_pkg::*;
    logic        ref_clk, rst, ck, x32_mode, cke, init_done, init_violation;
    logic [1:0]  cas_lat, ba;
    logic [3:0]  cmd_n, banks_open;
    logic [12:0] addr;
    lcs_mask_t   dm, dqs_i, dq_oe, dqs_o, dqs_oe;
    lcs_word_t   dq_i, dq_o;
    lcs_pwr_e    pwr_state;
    int          n_mismatch = 0;
    int          compares = 0;
    // Short idle period keeps the run brief.
    lcs_top #(.INIT_IDLE_CYC(20)) DUT (
        .ref_clk, .rst, .ck, .cke, .cs_n(cmd_n[3]), .ras_n(cmd_n[2]),
        .cas_n(cmd_n[1]), .we_n(cmd_n[0]), .ba, .addr, .x32_mode, .cas_lat,
        .dm, .dqs_i, .dq_i, .dq_o, .dq_oe, .dqs_o, .dqs_oe, .pwr_state,
        .banks_open, .init_done, .init_violation);
    lcs_ctrl_model ctl (.ck, .cke, .cmd_n, .ba, .addr, .dm, .dqs_i, .dq_i);
    // Link clock offset from the core clock.
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        ck = 1'b0;
        #13;
        forever #40 ck = ~ck;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic idle(input int n);
        repeat (n) @(negedge ck);
    endtask : idle
    // Masked bytes keep the older word.
    function automatic lcs_word_t merge(input lcs_word_t a, input lcs_word_t b,
                                        input lcs_mask_t m);
        for (int i = 0; i < 4; i++)
            merge[8*i +: 8] = m[i] ? a[8*i +: 8] : b[8*i +: 8];
    endfunction : merge
    // Read at CAS latency 2.
    task automatic rd_check(input logic [1:0] b, input logic [12:0] a,
                            input lcs_word_t e [4], input lcs_mask_t oe);
        ctl.issue(`LCS_CMD_RD, b, a, 1'b1);
        idle(2);
        for (int i = 0; i < 4; i++) begin
            check(dq_o, e[i]);
            check(32'(dq_oe), 32'(oe));
            check(32'(dqs_o & oe), (i % 2 == 0) ? 32'(oe) : 32'h0);
            idle(1);
        end
    endtask : rd_check
    // Write, overwrite through masks, read back.
    task automatic lane_run(input logic [1:0] bk, input lcs_mask_t m [4],
                            input lcs_word_t keep, input lcs_mask_t oe);
        lcs_word_t a [4], b [4], e [4];
        lcs_mask_t z [4];
        for (int i = 0; i < 4; i++) begin
            a[i] = {4{8'h11 * 8'(i + 1)}};
            b[i] = ~a[i];
            e[i] = merge(a[i], b[i], m[i]) & keep;
            z[i] = 4'h0;
        end
        ctl.issue(`LCS_CMD_ACT, bk, 13'h0, 1'b1);
        idle(2);
        ctl.issue(`LCS_CMD_WR, bk, 13'h0, 1'b1);
        ctl.burst(a, z);
        ctl.issue(`LCS_CMD_WR, bk, 13'h0, 1'b1);
        ctl.burst(b, m);
        idle(2);
        rd_check(bk, 13'h400, e, oe);
        idle(3);
        check(32'(banks_open), 32'h0);
    endtask : lane_run
    task automatic t_init;
        for (int i = 0; i < 100 && init_done !== 1'b1; i++)
            idle(1);
        check(32'(init_done), 32'h1);
        if (init_done !== 1'b1)
            close_out();
        idle(3);
        $display("t_init done");
    endtask : t_init
    task automatic t_x32;
        lane_run(2'h1, '{4'h0, 4'h5, 4'ha, 4'hf}, 32'hffffffff, 4'hf);
        $display("t_x32 done");
    endtask : t_x32
    task automatic t_x16;
        @(negedge ck);
        x32_mode = 1'b0;
        idle(4);
        lane_run(2'h2, '{4'h1, 4'h2, 4'h0, 4'h3}, 32'h0000ffff, 4'h3);
        $display("t_x16 done");
    endtask : t_x16
    // Active, then precharge power-down.
    task automatic t_pwr;
        ctl.issue(`LCS_CMD_ACT, 2'h0, 13'h0, 1'b1);
        ctl.issue(`LCS_CMD_NOP, 2'h0, 13'h0, 1'b0);
        idle(3);
        check(32'(pwr_state), 32'(LCS_PWR_PD_ACT));
        check(32'(banks_open), 32'h1);
        ctl.issue(`LCS_CMD_NOP, 2'h0, 13'h0, 1'b1);
        idle(2);
        ctl.issue(`LCS_CMD_PRE, 2'h3, 13'h400, 1'b1);
        idle(3);
        check(32'(banks_open), 32'h0);
        ctl.issue(`LCS_CMD_NOP, 2'h0, 13'h0, 1'b0);
        idle(3);
        check(32'(pwr_state), 32'(LCS_PWR_PD_PRE));
        ctl.issue(`LCS_CMD_NOP, 2'h0, 13'h0, 1'b1);
        idle(3);
        check(32'(pwr_state), 32'(LCS_PWR_ACTIVE));
        $display("t_pwr done");
    endtask : t_pwr
    // Auto refresh, then self refresh.
    task automatic t_sr;
        ctl.issue(`LCS_CMD_REF, 2'h0, 13'h0, 1'b1);
        idle(4);
        check(32'(pwr_state), 32'(LCS_PWR_ACTIVE));
        ctl.issue(`LCS_CMD_REF, 2'h0, 13'h0, 1'b0);
        idle(20);
        check(32'(pwr_state), 32'(LCS_PWR_SELF_REF));
        ctl.issue(`LCS_CMD_NOP, 2'h0, 13'h0, 1'b1);
        idle(3);
        check(32'(pwr_state), 32'(LCS_PWR_ACTIVE));
        $display("t_sr done");
    endtask : t_sr
    initial begin
        {rst, x32_mode, cas_lat} = {1'b1, 1'b1, 2'h2};
        idle(2);
        rst = 1'b0;
        t_init();
        t_x32();
        t_x16();
        t_pwr();
        t_sr();
        check(32'(init_violation), 32'h0);
        close_out();
    end
    // A hang counts as a mismatch.
    initial begin
        #500us;
        n_mismatch++;
        close_out();
    end
endmodule : testbench
`default_nettype wire
